// [include/cpu_flags_interrupt_pkg.sv]
// Constants and types of the interrupt sequencer.
// Assumes one core clock and byte-wide memory.
package cpu_flags_interrupt_pkg;

    // ==========================================================
    // Condition code register layout
    localparam int CCR_CARRY = 0;
    localparam int CCR_ZERO = 1;
    localparam int CCR_NEG = 2;
    localparam int CCR_MASK = 3;
    localparam int CCR_HALF = 4;
    localparam logic [7:0] CCR_FIXED_ONES = 8'hE0;
    localparam logic [7:0] CCR_RESET = 8'hE8;

    // ==========================================================
    // Vector table
    localparam logic [15:0] VEC_RESET = 16'h3FFE;
    localparam logic [15:0] VEC_SOFT = 16'h3FFC;
    localparam logic [15:0] VEC_EXT = 16'h3FFA;
    localparam logic [15:0] VEC_STEP = 16'h0002;

    // ==========================================================
    // Stack window and frame
    localparam logic [9:0] STACK_PAGE = 10'h003;
    localparam logic [5:0] STACK_TOP = 6'h3F;
    localparam logic [2:0] FRAME_BYTES = 3'h5;

    // ==========================================================
    // Timing
    localparam int MUL_CYCLES = 11;
    localparam int STACK_OVERHEAD_CYCLES = 10;

    // ==========================================================
    // Types
    typedef enum logic [3:0] {
        OP_ADD = 4'h0,
        OP_ADC = 4'h1,
        OP_SUB = 4'h2,
        OP_SBC = 4'h3,
        OP_AND = 4'h4,
        OP_ORA = 4'h5,
        OP_EOR = 4'h6,
        OP_LOAD = 4'h7,
        OP_CLC = 4'h8,
        OP_SEC = 4'h9,
        OP_CLI = 4'hA,
        OP_SEI = 4'hB,
        OP_MUL = 4'hC
    } alu_op_type;

    typedef enum logic [4:0] {
        S_IDLE = 5'h01,
        S_PUSH = 5'h02,
        S_VEC = 5'h04,
        S_PULL = 5'h08,
        S_MUL = 5'h10
    } seq_state_type;

endpackage : cpu_flags_interrupt_pkg

// [src/cpu_flags_interrupt_sequencer.sv]
// Flags, multiply unit and interrupt sequencer of an 8-bit core.
// Assumes core, peripheral flags and memory all run on clk_i.
// Summary of operation
// - Add and add-with-carry set half-carry on carry from bit 3 into 4.
// - Unmasked request: stack registers, then set mask, then fetch vector.
// - Request while masked stays pending and is taken once mask clears.
// - Return pulls all stacked registers, restoring the cleared mask.
// - Reset sets the mask; only an executed instruction clears it.
// - Negative flag follows the sign bit of the result.
// - Zero flag set when the result byte is zero.
// - Carry on carry out of bit 7 or borrow; some ops set or clear it.
// - Multiply runs as add-and-shift steps taking 11 clock cycles.
// - Hardware request waits until the current instruction completes.
// - Hardware entry only when mask clear and source enable set.
// - After stacking, the pending source with highest vector wins.
// - Software trap sequence runs regardless of the mask.
// - Service address read from a two-byte vector table entry.
// - Vectors fill top sixteen bytes, reset highest, then descending sources.
// - Eight causes accepted; timer overflow, compare, capture share one vector.
// - Latency at most longest instruction plus 10 cycles of overhead.
// - After return, execution resumes at the instruction due next.
// - Entry uses five stack bytes; stack wraps within a 64-byte window.
// - Top three condition code bits always read as ones.
//
// The address-and-strobe port and the register addresses are this design's own decisions.
`timescale 1ns/1ps

module cpu_flags_interrupt_sequencer
    import cpu_flags_interrupt_pkg::*;
#(
    parameter int NUM_HW = 6
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic alu_start_i,
    input wire cpu_flags_interrupt_pkg::alu_op_type alu_op_i,
    input wire logic [7:0] alu_a_i,
    input wire logic [7:0] alu_b_i,
    input wire logic insn_done_i,
    input wire logic soft_trap_instruction_i,
    input wire logic return_from_service_i,
    input wire logic [NUM_HW-1:0] src_flag_i,
    input wire logic [NUM_HW-1:0] src_enable_i,
    input wire logic [15:0] pc_i,
    input wire logic [7:0] x_i,
    input wire logic [7:0] a_i,
    input wire logic [7:0] mem_rdata_i,
    output logic [7:0] alu_result_o,
    output logic [7:0] alu_result_hi_o,
    output logic alu_done_o,
    output logic [7:0] condition_code_reg_o,
    output logic [15:0] mem_addr_o,
    output logic [7:0] mem_wdata_o,
    output logic mem_wr_o,
    output logic mem_rd_o,
    output logic [15:0] pc_o,
    output logic [7:0] x_o,
    output logic [7:0] a_o,
    output logic pc_load_o,
    output logic restore_o,
    output logic [NUM_HW-1:0] hw_ack_o,
    output logic soft_ack_o,
    output logic [15:0] sp_o,
    output logic busy_o
);
    import cpu_flags_interrupt_pkg::*;

    // ==========================================================
    // Elaboration check
    if (NUM_HW < 1 || NUM_HW > 6) begin : g_bad_num_hw
        $error("NUM_HW must lie between 1 and 6");
    end

    // ==========================================================
    // Functions
    function automatic logic [1:0] nz_of(input logic [7:0] v);
        nz_of = {v[7], v == 8'h00};
    endfunction : nz_of

    function automatic logic [15:0] stack_addr(input logic [5:0] p);
        stack_addr = {STACK_PAGE, p};
    endfunction : stack_addr

    // ==========================================================
    // State
    seq_state_type state;
    logic [7:0] condition_code_reg;
    logic [5:0] sp;
    logic [3:0] cnt;
    logic soft_pend;
    logic take_soft;
    logic [NUM_HW-1:0] sel_src;
    logic [15:0] vec_base;
    logic [7:0] vec_hi;
    logic [15:0] mul_acc;
    logic [7:0] mul_mcand;
    logic [7:0] mul_mplier;
    logic [15:0] frame_pc;
    logic [7:0] frame_x;
    logic [7:0] frame_a;

    // ==========================================================
    // Combinational ALU
    wire logic mask = condition_code_reg[CCR_MASK];
    wire logic cin = (alu_op_i == OP_ADC || alu_op_i == OP_SBC) ? condition_code_reg[CCR_CARRY] : 1'b0;
    wire logic [8:0] sum9 = {1'b0, alu_a_i} + {1'b0, alu_b_i} + {8'h00, cin};
    wire logic [4:0] sum_low = {1'b0, alu_a_i[3:0]} + {1'b0, alu_b_i[3:0]} + {4'h0, cin};
    wire logic [8:0] diff9 = {1'b0, alu_a_i} - {1'b0, alu_b_i} - {8'h00, cin};
    wire logic is_add = alu_op_i == OP_ADD || alu_op_i == OP_ADC;
    wire logic is_sub = alu_op_i == OP_SUB || alu_op_i == OP_SBC;
    wire logic is_logic = alu_op_i == OP_AND || alu_op_i == OP_ORA || alu_op_i == OP_EOR
        || alu_op_i == OP_LOAD;
    wire logic [7:0] alu_value =
        is_add ? sum9[7:0] :
        is_sub ? diff9[7:0] :
        alu_op_i == OP_AND ? (alu_a_i & alu_b_i) :
        alu_op_i == OP_ORA ? (alu_a_i | alu_b_i) :
        alu_op_i == OP_EOR ? (alu_a_i ^ alu_b_i) : alu_b_i;
    wire logic [1:0] alu_nz = nz_of(alu_value);
    wire logic alu_go = alu_start_i && state == S_IDLE;

    logic [7:0] next_ccr_alu;
    always_comb begin
        next_ccr_alu = condition_code_reg;
        if (is_add) begin
            next_ccr_alu[CCR_HALF] = sum_low[4];
            next_ccr_alu[CCR_CARRY] = sum9[8];
        end
        if (is_sub) begin
            next_ccr_alu[CCR_CARRY] = diff9[8];
        end
        if (is_add || is_sub || is_logic) begin
            next_ccr_alu[CCR_NEG] = alu_nz[1];
            next_ccr_alu[CCR_ZERO] = alu_nz[0];
        end
        if (alu_op_i == OP_CLC) begin
            next_ccr_alu[CCR_CARRY] = 1'b0;
        end
        if (alu_op_i == OP_SEC) begin
            next_ccr_alu[CCR_CARRY] = 1'b1;
        end
        if (alu_op_i == OP_CLI) begin
            next_ccr_alu[CCR_MASK] = 1'b0;
        end
        if (alu_op_i == OP_SEI) begin
            next_ccr_alu[CCR_MASK] = 1'b1;
        end
    end

    // ==========================================================
    // Interrupt decision and priority
    wire logic [NUM_HW-1:0] hw_pend = src_flag_i & src_enable_i;
    wire logic hw_take = !mask && (|hw_pend);
    wire logic enter = state == S_IDLE && insn_done_i && !alu_go
        && (hw_take || soft_pend || soft_trap_instruction_i);
    wire logic start_pull = state == S_IDLE && return_from_service_i && !alu_go;

    logic [NUM_HW-1:0] prio_sel;
    always_comb begin
        prio_sel = '0;
        for (int i = NUM_HW - 1; i >= 0; i--) begin
            if (hw_pend[i]) begin
                prio_sel = '0;
                prio_sel[i] = 1'b1;
            end
        end
    end

    // Source 0 has the external vector, each next two bytes lower
    logic [15:0] prio_vec;
    always_comb begin
        prio_vec = VEC_EXT;
        for (int i = 0; i < NUM_HW; i++) begin
            if (prio_sel[i]) begin
                prio_vec = VEC_EXT - 16'(i) * VEC_STEP;
            end
        end
    end

    logic [7:0] push_byte;
    always_comb begin
        unique case (cnt[2:0])
            3'h0: push_byte = pc_i[7:0];
            3'h1: push_byte = pc_i[15:8];
            3'h2: push_byte = x_i;
            3'h3: push_byte = a_i;
            default: push_byte = condition_code_reg;
        endcase
    end

    wire logic last_push = cnt == 4'(FRAME_BYTES - 3'h1);
    wire logic [5:0] sp_up = sp + 6'h01;

    // ==========================================================
    // Sequencer
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state <= S_IDLE;
            condition_code_reg <= CCR_RESET;
            sp <= STACK_TOP;
            cnt <= 4'h0;
            soft_pend <= 1'b0;
            take_soft <= 1'b0;
            sel_src <= '0;
            vec_base <= VEC_RESET;
            vec_hi <= 8'h00;
            mul_acc <= 16'h0000;
            mul_mcand <= 8'h00;
            mul_mplier <= 8'h00;
            frame_pc <= 16'h0000;
            frame_x <= 8'h00;
            frame_a <= 8'h00;
            alu_result_o <= 8'h00;
            alu_result_hi_o <= 8'h00;
            alu_done_o <= 1'b0;
            mem_addr_o <= 16'h0000;
            mem_wdata_o <= 8'h00;
            mem_wr_o <= 1'b0;
            mem_rd_o <= 1'b0;
            pc_load_o <= 1'b0;
            restore_o <= 1'b0;
            hw_ack_o <= '0;
            soft_ack_o <= 1'b0;
        end else begin
            alu_done_o <= 1'b0;
            mem_wr_o <= 1'b0;
            mem_rd_o <= 1'b0;
            pc_load_o <= 1'b0;
            restore_o <= 1'b0;
            hw_ack_o <= '0;
            soft_ack_o <= 1'b0;
            // A new trap beside its acceptance stays pending
            if (soft_trap_instruction_i) begin
                soft_pend <= 1'b1;
            end
            unique case (state)
                S_IDLE: begin
                    cnt <= 4'h0;
                    if (alu_go && alu_op_i == OP_MUL) begin
                        mul_acc <= 16'h0000;
                        mul_mcand <= alu_a_i;
                        mul_mplier <= alu_b_i;
                        state <= S_MUL;
                    end else if (alu_go) begin
                        alu_result_o <= alu_value;
                        alu_done_o <= 1'b1;
                        condition_code_reg <= next_ccr_alu | CCR_FIXED_ONES;
                    end else if (enter) begin
                        // Unmasked hardware goes before a trap
                        take_soft <= !hw_take;
                        if (!hw_take) begin
                            soft_pend <= soft_trap_instruction_i && soft_pend;
                        end
                        state <= S_PUSH;
                    end else if (start_pull) begin
                        state <= S_PULL;
                    end
                end
                S_PUSH: begin
                    mem_addr_o <= stack_addr(sp);
                    mem_wdata_o <= push_byte;
                    mem_wr_o <= 1'b1;
                    sp <= sp - 6'h01;
                    cnt <= cnt + 4'h1;
                    if (last_push) begin
                        condition_code_reg[CCR_MASK] <= 1'b1;
                        sel_src <= take_soft ? '0 : prio_sel;
                        vec_base <= take_soft ? VEC_SOFT : prio_vec;
                        cnt <= 4'h0;
                        state <= S_VEC;
                    end
                end
                S_VEC: begin
                    cnt <= cnt + 4'h1;
                    mem_addr_o <= vec_base + {15'h0000, cnt[0]};
                    mem_rd_o <= !cnt[1];
                    if (cnt == 4'h2) begin
                        vec_hi <= mem_rdata_i;
                    end else if (cnt == 4'h3) begin
                        frame_pc <= {vec_hi, mem_rdata_i};
                        pc_load_o <= 1'b1;
                        hw_ack_o <= sel_src;
                        soft_ack_o <= take_soft;
                        state <= S_IDLE;
                    end
                end
                S_PULL: begin
                    cnt <= cnt + 4'h1;
                    if (cnt < 4'(FRAME_BYTES)) begin
                        mem_addr_o <= stack_addr(sp_up);
                        mem_rd_o <= 1'b1;
                        sp <= sp_up;
                    end
                    unique case (cnt)
                        4'h2: condition_code_reg <= mem_rdata_i | CCR_FIXED_ONES;
                        4'h3: frame_a <= mem_rdata_i;
                        4'h4: frame_x <= mem_rdata_i;
                        4'h5: frame_pc[15:8] <= mem_rdata_i;
                        4'h6: begin
                            frame_pc[7:0] <= mem_rdata_i;
                            restore_o <= 1'b1;
                            state <= S_IDLE;
                        end
                        default: begin
                        end
                    endcase
                end
                S_MUL: begin
                    cnt <= cnt + 4'h1;
                    if (cnt < 4'h8) begin
                        if (mul_mplier[0]) begin
                            mul_acc <= mul_acc + ({8'h00, mul_mcand} << cnt[2:0]);
                        end
                        mul_mplier <= mul_mplier >> 1;
                    end
                    if (cnt == 4'(MUL_CYCLES - 1)) begin
                        alu_result_o <= mul_acc[7:0];
                        alu_result_hi_o <= mul_acc[15:8];
                        alu_done_o <= 1'b1;
                        condition_code_reg[CCR_HALF] <= 1'b0;
                        condition_code_reg[CCR_CARRY] <= 1'b0;
                        state <= S_IDLE;
                    end
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // Registered views
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            condition_code_reg_o <= CCR_RESET;
            pc_o <= VEC_RESET;
            x_o <= 8'h00;
            a_o <= 8'h00;
            sp_o <= {STACK_PAGE, STACK_TOP};
            busy_o <= 1'b0;
        end else begin
            condition_code_reg_o <= condition_code_reg | CCR_FIXED_ONES;
            pc_o <= frame_pc;
            x_o <= frame_x;
            a_o <= frame_a;
            sp_o <= stack_addr(sp);
            busy_o <= state != S_IDLE;
        end
    end

endmodule : cpu_flags_interrupt_sequencer

// [tb/cpu_flags_interrupt_sequencer_assertions.sv]
// Port-level checker for the sequencer.
// Assumes one clock and async active-high reset.
`timescale 1ns/1ps

module cpu_flags_interrupt_sequencer_assertions
    import cpu_flags_interrupt_pkg::*;
#(
    parameter int NUM_HW = 6
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic alu_start_i,
    input wire cpu_flags_interrupt_pkg::alu_op_type alu_op_i,
    input wire logic [7:0] alu_a_i,
    input wire logic [7:0] alu_b_i,
    input wire logic return_from_service_i,
    input wire logic [7:0] mem_rdata_i,
    input wire logic alu_done_o,
    input wire logic [7:0] condition_code_reg_o,
    input wire logic [15:0] mem_addr_o,
    input wire logic mem_wr_o,
    input wire logic mem_rd_o,
    input wire logic [15:0] pc_o,
    input wire logic pc_load_o,
    input wire logic restore_o,
    input wire logic [NUM_HW-1:0] hw_ack_o,
    input wire logic soft_ack_o,
    input wire logic busy_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // ==========================================================
    // Sequences
    sequence s_push; mem_wr_o [*5]; endsequence
    sequence s_fetch; mem_rd_o ##1 mem_rd_o ##2 pc_load_o; endsequence
    sequence s_pull; mem_rd_o [*5] ##2 restore_o; endsequence
    sequence s_add; alu_start_i && !busy_o && alu_op_i == OP_ADD; endsequence

    // ==========================================================
    // Properties
    property p_half;
        s_add |-> ##2 condition_code_reg_o[CCR_HALF] ==
            (({1'b0, $past(alu_a_i[3:0], 2)} + {1'b0, $past(alu_b_i[3:0], 2)}) > 5'h0F);
    endproperty
    a_half: assert property (p_half) else $error("half carry wrong");
    property p_carry;
        s_add |-> ##2 condition_code_reg_o[CCR_CARRY] ==
            (({1'b0, $past(alu_a_i, 2)} + {1'b0, $past(alu_b_i, 2)}) > 9'h0FF);
    endproperty
    a_carry: assert property (p_carry) else $error("carry wrong");
    property p_mul;
        alu_start_i && !busy_o && alu_op_i == OP_MUL
            |=> (!alu_done_o) [*8] ##1 (!alu_done_o) [*3] ##1 alu_done_o;
    endproperty
    a_mul: assert property (p_mul) else $error("multiply length wrong");
    property p_entry;
        $rose(mem_wr_o) |-> s_push ##1 s_fetch;
    endproperty
    a_entry: assert property (p_entry) else $error("entry order wrong");
    property p_mask;
        $fell(mem_wr_o) |=> condition_code_reg_o[CCR_MASK];
    endproperty
    a_mask: assert property (p_mask) else $error("mask not set");
    property p_stack;
        mem_wr_o && $past(mem_wr_o) |-> mem_addr_o[15:6] == 10'h003 &&
            mem_addr_o[5:0] == $past(mem_addr_o[5:0]) - 6'h01;
    endproperty
    a_stack: assert property (p_stack) else $error("stack address wrong");
    property p_return;
        return_from_service_i && !busy_o |=> ##1 s_pull;
    endproperty
    a_return: assert property (p_return) else $error("return order wrong");
    property p_unmask;
        $fell(condition_code_reg_o[CCR_MASK])
            |-> $past(alu_start_i && alu_op_i == OP_CLI, 2) || $past(mem_rd_o, 2);
    endproperty
    a_unmask: assert property (p_unmask) else $error("mask cleared alone");
    property p_vector;
        pc_load_o |=> pc_o == {$past(mem_rdata_i, 3), $past(mem_rdata_i, 2)};
    endproperty
    a_vector: assert property (p_vector) else $error("vector load wrong");
    property p_ack;
        (|hw_ack_o) || soft_ack_o |-> pc_load_o && $onehot({hw_ack_o, soft_ack_o});
    endproperty
    a_ack: assert property (p_ack) else $error("ack wrong");
    property p_ones;
        condition_code_reg_o[7:5] == 3'b111;
    endproperty
    a_ones: assert property (p_ones) else $error("fixed bits wrong");
endmodule : cpu_flags_interrupt_sequencer_assertions

bind cpu_flags_interrupt_sequencer cpu_flags_interrupt_sequencer_assertions #(
    .NUM_HW(NUM_HW)
) u_chk (.clk_i, .rst_i, .alu_start_i, .alu_op_i, .alu_a_i, .alu_b_i,
    .return_from_service_i, .mem_rdata_i, .alu_done_o, .condition_code_reg_o, .mem_addr_o,
    .mem_wr_o, .mem_rd_o, .pc_o, .pc_load_o, .restore_o, .hw_ack_o, .soft_ack_o, .busy_o);

// [tb/cpu_flags_interrupt_sequencer_tb.sv]
// Self-checking bench for the interrupt sequencer.
// Assumes the far-side model and checker are compiled too.
`timescale 1ns/1ps

module cpu_flags_interrupt_sequencer_tb;
    import cpu_flags_interrupt_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic alu_start_i = 1'b0;
    alu_op_type alu_op_i = OP_ADD;
    logic [7:0] alu_a_i = 8'h00, alu_b_i = 8'h00, x_i = 8'h00, a_i = 8'h00;
    logic insn_done_i = 1'b0, soft_trap_instruction_i = 1'b0, return_from_service_i = 1'b0;
    logic [5:0] src_enable_i = 6'h1F, raise = 6'h00, src_flag_i, hw_ack_o;
    logic [15:0] pc_i = 16'h0000, mem_addr_o, pc_o, sp_o;
    logic [7:0] alu_result_o, alu_result_hi_o, condition_code_reg_o, mem_wdata_o, mem_rdata_i;
    logic [7:0] x_o, a_o, condition_code_reg;
    logic alu_done_o, mem_wr_o, mem_rd_o, pc_load_o, restore_o, soft_ack_o, busy_o;
    logic [7:0] wq[$], stk[$];
    int sp_m = 'hFF, n_errors = 0, n_checks = 0;

    cpu_flags_interrupt_sequencer #(.NUM_HW(6)) dut (.clk_i, .rst_i, .alu_start_i, .alu_op_i,
        .alu_a_i, .alu_b_i, .insn_done_i, .soft_trap_instruction_i, .return_from_service_i,
        .src_flag_i, .src_enable_i, .pc_i, .x_i, .a_i, .mem_rdata_i, .alu_result_o,
        .alu_result_hi_o, .alu_done_o, .condition_code_reg_o, .mem_addr_o, .mem_wdata_o,
        .mem_wr_o, .mem_rd_o, .pc_o, .x_o, .a_o, .pc_load_o, .restore_o, .hw_ack_o, .soft_ack_o,
        .sp_o, .busy_o);
    irq_source_memory_model far_end (.clk_i, .rst_i, .mem_addr_i(mem_addr_o),
        .mem_wdata_i(mem_wdata_o), .mem_wr_i(mem_wr_o), .mem_rd_i(mem_rd_o), .raise_i(raise),
        .hw_ack_i(hw_ack_o), .mem_rdata_o(mem_rdata_i), .src_flag_o(src_flag_i));

    always #12.5 clk_i = ~clk_i;
    always @(posedge clk_i) if (mem_wr_o === 1'b1) wq.push_back(mem_wdata_o);

    // ==========================================================
    // Tasks
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic await(ref logic s, output int n);
        n = 0;
        #1;
        while (s !== 1'b1 && n < 30) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        if (s !== 1'b1) n_errors++;
    endtask : await
    task automatic alu(input alu_op_type op, input logic [7:0] a, input logic [7:0] b);
        int r, cin, n;
        @(posedge clk_i);
        alu_start_i <= 1'b1;
        alu_op_i <= op;
        alu_a_i <= a;
        alu_b_i <= b;
        @(posedge clk_i);
        alu_start_i <= 1'b0;
        await(alu_done_o, n);
        cin = (op == OP_ADC || op == OP_SBC) ? int'(condition_code_reg[0]) : 0;
        r = 0;
        case (op)
            OP_ADD, OP_ADC: begin
                r = a + b + cin;
                condition_code_reg[4] = ((a & 15) + (b & 15) + cin) > 15;
                condition_code_reg[0] = r > 255;
            end
            OP_SUB, OP_SBC: begin
                r = a - b - cin;
                condition_code_reg[0] = r < 0;
            end
            OP_AND: r = a & b;
            OP_ORA: r = a | b;
            OP_EOR: r = a ^ b;
            OP_LOAD: r = b;
            OP_MUL: begin
                r = a * b;
                condition_code_reg[4] = 1'b0;
                condition_code_reg[0] = 1'b0;
            end
            OP_CLC: condition_code_reg[0] = 1'b0;
            OP_SEC: condition_code_reg[0] = 1'b1;
            OP_CLI: condition_code_reg[3] = 1'b0;
            default: condition_code_reg[3] = 1'b1;
        endcase
        if (op <= OP_LOAD) begin
            condition_code_reg[2] = r[7];
            condition_code_reg[1] = r[7:0] == 8'h00;
            chk("result", 16'(r[7:0]), 16'(alu_result_o));
        end
        if (op == OP_MUL) chk("product", r[15:0], {alu_result_hi_o, alu_result_o});
        repeat (2) @(posedge clk_i);
        #1;
        chk("flags", 16'(condition_code_reg), 16'(condition_code_reg_o));
    endtask : alu
    task automatic pend(input logic [5:0] bits);
        @(posedge clk_i);
        raise <= bits;
        @(posedge clk_i);
        raise <= 6'h00;
    endtask : pend
    task automatic quiet();
        int k = 0;
        @(posedge clk_i);
        insn_done_i <= 1'b1;
        @(posedge clk_i);
        insn_done_i <= 1'b0;
        repeat (12) begin
            @(posedge clk_i);
            #1;
            k += int'(mem_wr_o === 1'b1 || busy_o === 1'b1);
        end
        chk("no_entry", 16'h0000, 16'(k));
    endtask : quiet
    task automatic intr(input logic [15:0] vec, input logic [6:0] ack);
        logic [7:0] fr [5];
        int n;
        fr = '{8'($urandom), 8'($urandom) & 8'h3F, 8'($urandom), 8'($urandom), condition_code_reg};
        @(posedge clk_i);
        pc_i <= {fr[1], fr[0]};
        x_i <= fr[2];
        a_i <= fr[3];
        insn_done_i <= 1'b1;
        soft_trap_instruction_i <= ack[6];
        wq.delete();
        @(posedge clk_i);
        insn_done_i <= 1'b0;
        soft_trap_instruction_i <= 1'b0;
        await(pc_load_o, n);
        chk("latency_ok", 16'h0001, 16'(n <= 10));
        chk("ack", 16'(ack), 16'({soft_ack_o, hw_ack_o}));
        for (int i = 0; i < 5; i++) begin
            chk("push", 16'(fr[i]), 16'(wq[i]));
            stk.push_back(fr[i]);
        end
        condition_code_reg[3] = 1'b1;
        sp_m = 'hC0 + ((sp_m - 'hC5) & 'h3F);
        repeat (2) @(posedge clk_i);
        #1;
        chk("sp", 16'(sp_m), sp_o);
        chk("vector", {4'h2, vec[3:0], 8'h5A}, pc_o);
        chk("flags", 16'(condition_code_reg), 16'(condition_code_reg_o));
    endtask : intr
    task automatic ret();
        logic [15:0] pc;
        int n;
        @(posedge clk_i);
        return_from_service_i <= 1'b1;
        @(posedge clk_i);
        return_from_service_i <= 1'b0;
        await(restore_o, n);
        repeat (2) @(posedge clk_i);
        #1;
        condition_code_reg = stk.pop_back();
        chk("a", 16'(stk.pop_back()), 16'(a_o));
        chk("x", 16'(stk.pop_back()), 16'(x_o));
        pc[15:8] = stk.pop_back();
        pc[7:0] = stk.pop_back();
        sp_m = 'hC0 + ((sp_m - 'hBB) & 'h3F);
        chk("pc", pc, pc_o);
        chk("sp", 16'(sp_m), sp_o);
        chk("flags", 16'(condition_code_reg), 16'(condition_code_reg_o));
    endtask : ret
    task automatic finish_test();
        $display("Checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : finish_test

    // ==========================================================
    // Main sequence
    initial begin
        void'($urandom(32'h602C9874));
        repeat (2) @(posedge clk_i);
        #1;
        chk("flags", 16'h00E8, 16'(condition_code_reg_o));
        chk("pc", 16'h3FFE, pc_o);
        chk("sp", 16'h00FF, sp_o);
        @(posedge clk_i);
        rst_i <= 1'b0;
        condition_code_reg = 8'hE8;
        alu(OP_ADD, 8'h0F, 8'h01);
        alu(OP_ADD, 8'hFF, 8'h01);
        alu(OP_ADC, 8'h7F, 8'h00);
        alu(OP_SUB, 8'h00, 8'h01);
        alu(OP_SBC, 8'h05, 8'h04);
        alu(OP_MUL, 8'hFF, 8'hFF);
        for (int i = 0; i < 60; i++) begin
            alu(alu_op_type'($urandom_range(0, 12)), 8'($urandom), 8'($urandom));
        end
        alu(OP_SEI, 8'h00, 8'h00);
        pend(6'h0A);
        quiet();
        alu(OP_CLI, 8'h00, 8'h00);
        intr(16'h3FF8, 7'h02);
        ret();
        intr(16'h3FF4, 7'h08);
        ret();
        for (int k = 0; k < 5; k++) begin
            pend(6'(1 << k));
            intr(16'h3FFA - 16'(2 * k), 7'(1 << k));
            ret();
        end
        pend(6'h20);
        quiet();
        @(posedge clk_i);
        src_enable_i <= 6'h3F;
        intr(16'h3FF0, 7'h20);
        ret();
        alu(OP_SEI, 8'h00, 8'h00);
        for (int k = 0; k < 13; k++) begin
            intr(16'h3FFC, 7'h40);
        end
        finish_test();
    end

    initial begin
        #750000;
        n_errors++;
        finish_test();
    end
endmodule : cpu_flags_interrupt_sequencer_tb

// [tb/irq_source_memory_model.sv]
// Far-side model: peripheral request flags, stack RAM and vector table.
// Assumes sequencer strobes on clk_i.
`timescale 1ns/1ps

module irq_source_memory_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [15:0] mem_addr_i,
    input wire logic [7:0] mem_wdata_i,
    input wire logic mem_wr_i,
    input wire logic mem_rd_i,
    input wire logic [5:0] raise_i,
    input wire logic [5:0] hw_ack_i,
    output logic [7:0] mem_rdata_o,
    output logic [5:0] src_flag_o
);
    logic [7:0] ram [64];
    // Vector: hi byte {2, addr nibble}, lo byte 5A
    wire logic [7:0] vec_byte = mem_addr_i[0] ? 8'h5A : {4'h2, mem_addr_i[3:0]};
    wire logic in_table = mem_addr_i[15:4] == 12'h3FF;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            mem_rdata_o <= 8'h00;
            src_flag_o <= 6'h00;
        end else begin
            src_flag_o <= (src_flag_o | raise_i) & ~hw_ack_i;
            if (mem_wr_i) begin
                ram[mem_addr_i[5:0]] <= mem_wdata_i;
            end
            // Data stands one cycle, then toggles
            mem_rdata_o <= mem_rd_i ? (in_table ? vec_byte : ram[mem_addr_i[5:0]]) : ~mem_rdata_o;
        end
    end
endmodule : irq_source_memory_model
